//--- plc_pkg.sv
// constants shared by the link configuration register block and its serial port
package plc_pkg;

  localparam int PLC_NUM_REGS = 6;

  // register indices into the register file
  localparam int PLC_IDX_FEC = 0;
  localparam int PLC_IDX_CODE = 1;
  localparam int PLC_IDX_THR = 2;
  localparam int PLC_IDX_MAXW = 3;
  localparam int PLC_IDX_FORCE = 4;
  localparam int PLC_IDX_TEST = 5;

  // register offsets on the management address space
  localparam logic [15:0] PLC_OFF_FEC_DECODER_CONTROL = 16'h0510;
  localparam logic [15:0] PLC_OFF_LOW_POWER_CODE_SELECT = 16'h0514;
  localparam logic [15:0] PLC_OFF_LOW_POWER_CODE_THRESHOLDS = 16'h0515;
  localparam logic [15:0] PLC_OFF_LINKUP_MAX_WAIT = 16'h0518;
  localparam logic [15:0] PLC_OFF_LINK_FORCE_AND_MIN_WAIT = 16'h0519;
  localparam logic [15:0] PLC_OFF_TRANSMIT_TEST_PATTERN_CONTROL = 16'h0531;

  localparam logic [15:0] PLC_REG_OFFSET [PLC_NUM_REGS] = '{
    PLC_OFF_FEC_DECODER_CONTROL, PLC_OFF_LOW_POWER_CODE_SELECT,
    PLC_OFF_LOW_POWER_CODE_THRESHOLDS, PLC_OFF_LINKUP_MAX_WAIT,
    PLC_OFF_LINK_FORCE_AND_MIN_WAIT, PLC_OFF_TRANSMIT_TEST_PATTERN_CONTROL};

  // values after reset
  localparam logic [15:0] PLC_REG_RESET [PLC_NUM_REGS] = '{
    16'h2D50, 16'h08E3, 16'h0808, 16'h17CE, 16'h003D, 16'h0000};

  // writable bits; read-only reserved bits stay zero
  localparam logic [15:0] PLC_REG_WMASK [PLC_NUM_REGS] = '{
    16'hFFFF, 16'h0FFF, 16'h7F7F, 16'hFFFF, 16'h7FFF, 16'h01FF};

  // field positions
  localparam int PLC_FEC_SKIP_BIT = 15;
  localparam int PLC_SEND_WAKEUP_LSB = 9;
  localparam int PLC_SEND_DOZE_LSB = 6;
  localparam int PLC_EXPECT_WAKEUP_LSB = 3;
  localparam int PLC_EXPECT_DOZE_LSB = 0;
  localparam int PLC_WAKEUP_THR_LSB = 8;
  localparam int PLC_DOZE_THR_LSB = 0;
  localparam int PLC_FORCE_VAL_BIT = 11;
  localparam int PLC_FORCE_EN_BIT = 10;
  localparam int PLC_MINWAIT_LSB = 0;
  localparam int PLC_ORDER_BIT = 8;
  localparam int PLC_TEST7_DATA_LSB = 0;

  // wait timer unit
  localparam int PLC_CLK_MHZ = 250;
  localparam int PLC_TIMER_UNIT_US = 16;
  localparam int PLC_TIMER_UNIT_CYCLES = PLC_TIMER_UNIT_US * PLC_CLK_MHZ;

  // test mode codes on the mode select input
  localparam logic [2:0] PLC_TEST_MODE_4 = 3'h4;
  localparam logic [2:0] PLC_TEST_MODE_7 = 3'h7;

  // serial management frame
  localparam logic [4:0] PLC_PORT_ADDR = 5'h01;
  localparam logic [4:0] PLC_DEV_ADDR = 5'h1F;
  localparam logic [5:0] PLC_PREAMBLE_BITS = 6'h20;
  localparam logic [5:0] PLC_HDR_BITS = 6'h0E;
  localparam logic [5:0] PLC_TA_BITS = 6'h0F;
  localparam logic [5:0] PLC_DATA_FIRST = 6'h10;
  localparam logic [5:0] PLC_FRAME_BITS = 6'h20;
  localparam logic [1:0] PLC_OP_ADDR = 2'h0;
  localparam logic [1:0] PLC_OP_WRITE = 2'h1;
  localparam logic [1:0] PLC_OP_READ_INC = 2'h2;
  localparam logic [1:0] PLC_OP_READ = 2'h3;

  typedef enum logic [2:0] {
    PLC_LU_IDLE = 3'h0,
    PLC_LU_MINWAIT = 3'h1,
    PLC_LU_MAXWAIT = 3'h2,
    PLC_LU_UP = 3'h3,
    PLC_LU_FAIL = 3'h4
  } plc_link_state_type;

endpackage

//--- plc_mdio_slave.sv
// management serial port: indirect-address frames into register reads and writes
`timescale 1ns/1ps
`default_nettype none
module plc_mdio_slave (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out_r,
  output logic mdio_oe_r,
  output logic [15:0] addr_r,
  output logic wr_pulse_r,
  output logic [15:0] wr_data_r,
  input wire logic [15:0] rd_data
);

  logic [2:0] mdc_sync_r;
  logic [2:0] dat_sync_r;
  logic mdc_lvl_r;
  logic [5:0] ones_r;
  logic [5:0] cnt_r;
  logic [31:0] sh_r;
  logic [15:0] rd_hold_r;
  logic rd_op_r;
  logic hit_r;
  logic rise;
  logic fall;
  logic [5:0] cnt_nxt;
  logic [31:0] sh_nxt;

  // both pins cross in through three stages; clock edges count only when its later two stages agree
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mdc_sync_r <= 3'h0;
      dat_sync_r <= 3'h0;
      mdc_lvl_r <= 1'b0;
    end else begin
      mdc_sync_r <= {mdc_sync_r[1:0], mdc};
      dat_sync_r <= {dat_sync_r[1:0], mdio_in};
      if (mdc_sync_r[1] == mdc_sync_r[2]) begin
        mdc_lvl_r <= mdc_sync_r[2];
      end
    end
  end

  assign rise = (mdc_sync_r[1] == mdc_sync_r[2]) && mdc_sync_r[2] && !mdc_lvl_r;
  assign fall = (mdc_sync_r[1] == mdc_sync_r[2]) && !mdc_sync_r[2] && mdc_lvl_r;
  assign cnt_nxt = cnt_r + 6'h01;
  assign sh_nxt = {sh_r[30:0], dat_sync_r[2]};

  // frame receiver on clock rising edges
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ones_r <= 6'h00;
      cnt_r <= 6'h00;
      sh_r <= 32'h0000_0000;
      hit_r <= 1'b0;
      addr_r <= 16'h0000;
      wr_pulse_r <= 1'b0;
      wr_data_r <= 16'h0000;
    end else begin
      wr_pulse_r <= 1'b0;
      if (rise) begin
        sh_r <= sh_nxt;
        if (cnt_r == 6'h00) begin
          if (dat_sync_r[2]) begin
            if (ones_r != plc_pkg::PLC_PREAMBLE_BITS) begin
              ones_r <= ones_r + 6'h01;
            end
          end else begin
            if (ones_r == plc_pkg::PLC_PREAMBLE_BITS) begin
              cnt_r <= 6'h01;
            end
            ones_r <= 6'h00;
          end
        end else begin
          cnt_r <= cnt_nxt;
          if (cnt_nxt == plc_pkg::PLC_HDR_BITS) begin
            // start code 00, then port and device must match
            hit_r <= (sh_nxt[12] == 1'b0) && (sh_nxt[9:5] == plc_pkg::PLC_PORT_ADDR)
                     && (sh_nxt[4:0] == plc_pkg::PLC_DEV_ADDR);
          end
          if (cnt_nxt == plc_pkg::PLC_FRAME_BITS) begin
            cnt_r <= 6'h00;
            hit_r <= 1'b0;
            if (hit_r) begin
              case (sh_nxt[29:28])
                plc_pkg::PLC_OP_ADDR: addr_r <= sh_nxt[15:0];
                plc_pkg::PLC_OP_WRITE: begin
                  wr_pulse_r <= 1'b1;
                  wr_data_r <= sh_nxt[15:0];
                end
                plc_pkg::PLC_OP_READ_INC: addr_r <= addr_r + 16'h0001;
                default: addr_r <= addr_r;
              endcase
            end
          end
        end
      end
    end
  end

  // read data shifted out on falling edges, one bit per clock
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mdio_out_r <= 1'b0;
      mdio_oe_r <= 1'b0;
      rd_hold_r <= 16'h0000;
      rd_op_r <= 1'b0;
    end else begin
      // upper opcode bit marks both read kinds; writes never turn the pin around
      if (rise && cnt_nxt == plc_pkg::PLC_HDR_BITS) begin
        rd_hold_r <= rd_data;
        rd_op_r <= sh_nxt[11];
      end
      if (fall) begin
        if (hit_r && rd_op_r && cnt_r == plc_pkg::PLC_TA_BITS) begin
          mdio_oe_r <= 1'b1;
          mdio_out_r <= 1'b0;
        end else if (hit_r && rd_op_r && cnt_r >= plc_pkg::PLC_DATA_FIRST) begin
          mdio_oe_r <= 1'b1;
          mdio_out_r <= rd_hold_r[4'(5'h1F - 5'(cnt_r))];
        end else begin
          mdio_oe_r <= 1'b0;
          mdio_out_r <= 1'b0;
        end
      end
    end
  end

endmodule // plc_mdio_slave
`default_nettype wire

//--- plc_regs.sv
// link configuration registers: decoder skip, low-power codes, link-up timers, test patterns
//
// Notes on behaviour
// - fec_decode_skip high removes the decoder from the receive path; reset keeps it.
// - wake indication sends the send_wakeup_code field, reset 4.
// - sleep indication sends the send_doze_code field, reset 3.
// - received group equal to expect_wakeup_code counts as a wake code.
// - received group equal to expect_doze_code counts as a sleep code.
// - wake received only after threshold consecutive wake codes; mismatch restarts.
// - sleep received only after threshold consecutive sleep codes; mismatch restarts.
// - maximum link-up wait loads the 16-bit field, counted in 16 us units.
// - minimum link-up wait loads the 8-bit field, counted in 16 us units.
// - force enable replaces reported link status with the forced value.
// - forced value is ignored unless the force enable bit is set.
// - test mode 4 sends first set then second, or reversed when order bit set.
// - test mode 7 repeats the programmed data byte.
`timescale 1ns/1ps
`default_nettype none
module plc_regs (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out_r,
  output logic mdio_oe_r,
  output logic fec_decode_skip_r,
  input wire logic tx_wakeup_req,
  input wire logic tx_doze_req,
  output logic [2:0] tx_code_group_r,
  output logic tx_code_valid_r,
  input wire logic rx_code_valid,
  input wire logic [2:0] rx_code_group,
  output logic wakeup_received_r,
  output logic doze_received_r,
  input wire logic linkup_start,
  input wire logic link_ready,
  output logic link_status_r,
  output logic linkup_timeout_r,
  input wire logic [2:0] test_mode_sel,
  output logic test_second_set_r,
  output logic [7:0] test_data_r,
  output logic test_data_valid_r
);

  logic [15:0] addr;
  logic wr_pulse;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  logic [15:0] reg_r [plc_pkg::PLC_NUM_REGS];

  logic [6:0] wakeup_cnt_r;
  logic [6:0] doze_cnt_r;
  logic [6:0] wakeup_cnt_nxt;
  logic [6:0] doze_cnt_nxt;

  plc_pkg::plc_link_state_type lu_state_r;
  plc_pkg::plc_link_state_type lu_state_nxt;
  logic [11:0] unit_cnt_r;
  logic unit_tick;
  logic [7:0] min_left_r;
  logic [15:0] max_left_r;
  logic min_done;
  logic max_done;
  logic sm_link_up;
  logic test4_phase_r;

  // register field views
  logic [2:0] send_wakeup_code;
  logic [2:0] send_doze_code;
  logic [2:0] expect_wakeup_code;
  logic [2:0] expect_doze_code;
  logic [6:0] wakeup_repeat_threshold;
  logic [6:0] doze_repeat_threshold;
  logic [15:0] maxwait_init;
  logic [7:0] minwait_init;
  logic force_en;
  logic force_val;
  logic pattern_four_symbol_order;
  logic [7:0] test7_data;

  assign send_wakeup_code =
    reg_r[plc_pkg::PLC_IDX_CODE][plc_pkg::PLC_SEND_WAKEUP_LSB +: 3];
  assign send_doze_code =
    reg_r[plc_pkg::PLC_IDX_CODE][plc_pkg::PLC_SEND_DOZE_LSB +: 3];
  assign expect_wakeup_code =
    reg_r[plc_pkg::PLC_IDX_CODE][plc_pkg::PLC_EXPECT_WAKEUP_LSB +: 3];
  assign expect_doze_code =
    reg_r[plc_pkg::PLC_IDX_CODE][plc_pkg::PLC_EXPECT_DOZE_LSB +: 3];
  assign wakeup_repeat_threshold =
    reg_r[plc_pkg::PLC_IDX_THR][plc_pkg::PLC_WAKEUP_THR_LSB +: 7];
  assign doze_repeat_threshold =
    reg_r[plc_pkg::PLC_IDX_THR][plc_pkg::PLC_DOZE_THR_LSB +: 7];
  assign maxwait_init = reg_r[plc_pkg::PLC_IDX_MAXW];
  assign minwait_init = reg_r[plc_pkg::PLC_IDX_FORCE][plc_pkg::PLC_MINWAIT_LSB +: 8];
  assign force_en = reg_r[plc_pkg::PLC_IDX_FORCE][plc_pkg::PLC_FORCE_EN_BIT];
  assign force_val = reg_r[plc_pkg::PLC_IDX_FORCE][plc_pkg::PLC_FORCE_VAL_BIT];
  assign pattern_four_symbol_order =
    reg_r[plc_pkg::PLC_IDX_TEST][plc_pkg::PLC_ORDER_BIT];
  assign test7_data = reg_r[plc_pkg::PLC_IDX_TEST][plc_pkg::PLC_TEST7_DATA_LSB +: 8];

  plc_mdio_slave u_mdio (
    .core_clk(core_clk),
    .resetn(resetn),
    .mdc(mdc),
    .mdio_in(mdio_in),
    .mdio_out_r(mdio_out_r),
    .mdio_oe_r(mdio_oe_r),
    .addr_r(addr),
    .wr_pulse_r(wr_pulse),
    .wr_data_r(wr_data),
    .rd_data(rd_data)
  );

  // one generated register per map entry; masked bits never leave zero
  genvar gi;
  generate
    for (gi = 0; gi < plc_pkg::PLC_NUM_REGS; gi++) begin : g_reg
      always_ff @(posedge core_clk) begin
        if (!resetn) begin
          reg_r[gi] <= plc_pkg::PLC_REG_RESET[gi];
        end else if (wr_pulse && addr == plc_pkg::PLC_REG_OFFSET[gi]) begin
          reg_r[gi] <= wr_data & plc_pkg::PLC_REG_WMASK[gi];
        end
      end
    end
  endgenerate

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_data = 16'h0000;
    for (int i = 0; i < plc_pkg::PLC_NUM_REGS; i++) begin
      if (addr == plc_pkg::PLC_REG_OFFSET[i]) begin
        rd_data = reg_r[i];
      end
    end
  end

  // decoder skip control
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      fec_decode_skip_r <= 1'b0;
    end else begin
      fec_decode_skip_r <= reg_r[plc_pkg::PLC_IDX_FEC][plc_pkg::PLC_FEC_SKIP_BIT];
    end
  end

  // transmit code group; wake takes priority when both are asked for
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      tx_code_group_r <= 3'h0;
      tx_code_valid_r <= 1'b0;
    end else begin
      if (tx_wakeup_req) begin
        tx_code_group_r <= send_wakeup_code;
      end else if (tx_doze_req) begin
        tx_code_group_r <= send_doze_code;
      end else begin
        tx_code_group_r <= 3'h0;
      end
      tx_code_valid_r <= tx_wakeup_req | tx_doze_req;
    end
  end

  // consecutive match counters saturate so a long run cannot wrap past threshold
  always_comb begin
    wakeup_cnt_nxt = wakeup_cnt_r;
    doze_cnt_nxt = doze_cnt_r;
    if (rx_code_valid) begin
      if (rx_code_group == expect_wakeup_code) begin
        if (wakeup_cnt_r != 7'h7F) begin
          wakeup_cnt_nxt = wakeup_cnt_r + 7'h01;
        end
      end else begin
        wakeup_cnt_nxt = 7'h00;
      end
      if (rx_code_group == expect_doze_code) begin
        if (doze_cnt_r != 7'h7F) begin
          doze_cnt_nxt = doze_cnt_r + 7'h01;
        end
      end else begin
        doze_cnt_nxt = 7'h00;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wakeup_cnt_r <= 7'h00;
      doze_cnt_r <= 7'h00;
    end else begin
      wakeup_cnt_r <= wakeup_cnt_nxt;
      doze_cnt_r <= doze_cnt_nxt;
    end
  end

  // indications stay up while the run of matching groups continues
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wakeup_received_r <= 1'b0;
      doze_received_r <= 1'b0;
    end else begin
      wakeup_received_r <= (wakeup_cnt_nxt != 7'h00)
                           && (wakeup_cnt_nxt >= wakeup_repeat_threshold);
      doze_received_r <= (doze_cnt_nxt != 7'h00)
                         && (doze_cnt_nxt >= doze_repeat_threshold);
    end
  end

  // 16 us time base, held at zero while idle so each link-up starts clean
  assign unit_tick = (unit_cnt_r == 12'(plc_pkg::PLC_TIMER_UNIT_CYCLES - 1));

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      unit_cnt_r <= 12'h000;
    end else if (lu_state_r == plc_pkg::PLC_LU_IDLE || unit_tick) begin
      unit_cnt_r <= 12'h000;
    end else begin
      unit_cnt_r <= unit_cnt_r + 12'h001;
    end
  end

  assign min_done = (min_left_r == 8'h00);
  assign max_done = (max_left_r == 16'h0000);

  // wait timers are loaded on leaving idle; later register writes do not disturb them
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      min_left_r <= 8'h00;
      max_left_r <= 16'h0000;
    end else if (lu_state_r == plc_pkg::PLC_LU_IDLE) begin
      min_left_r <= minwait_init;
      max_left_r <= maxwait_init;
    end else if (unit_tick) begin
      if (!min_done) begin
        min_left_r <= min_left_r - 8'h01;
      end
      if (!max_done) begin
        max_left_r <= max_left_r - 16'h0001;
      end
    end
  end

  // link-up sequencing: no link before the minimum wait, failure after the maximum
  always_comb begin
    lu_state_nxt = lu_state_r;
    case (lu_state_r)
      plc_pkg::PLC_LU_IDLE: begin
        if (linkup_start) begin
          lu_state_nxt = plc_pkg::PLC_LU_MINWAIT;
        end
      end
      plc_pkg::PLC_LU_MINWAIT: begin
        if (max_done) begin
          lu_state_nxt = plc_pkg::PLC_LU_FAIL;
        end else if (min_done) begin
          lu_state_nxt = plc_pkg::PLC_LU_MAXWAIT;
        end
      end
      plc_pkg::PLC_LU_MAXWAIT: begin
        if (link_ready) begin
          lu_state_nxt = plc_pkg::PLC_LU_UP;
        end else if (max_done) begin
          lu_state_nxt = plc_pkg::PLC_LU_FAIL;
        end
      end
      plc_pkg::PLC_LU_UP: begin
        if (!link_ready) begin
          lu_state_nxt = plc_pkg::PLC_LU_IDLE;
        end
      end
      plc_pkg::PLC_LU_FAIL: begin
        lu_state_nxt = plc_pkg::PLC_LU_FAIL;
      end
      default: lu_state_nxt = plc_pkg::PLC_LU_IDLE;
    endcase
    if (!linkup_start) begin
      lu_state_nxt = plc_pkg::PLC_LU_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      lu_state_r <= plc_pkg::PLC_LU_IDLE;
    end else begin
      lu_state_r <= lu_state_nxt;
    end
  end

  assign sm_link_up = (lu_state_nxt == plc_pkg::PLC_LU_UP);

  // reported link status, optionally forced
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      link_status_r <= 1'b0;
      linkup_timeout_r <= 1'b0;
    end else begin
      if (force_en) begin
        link_status_r <= force_val;
      end else begin
        link_status_r <= sm_link_up;
      end
      linkup_timeout_r <= (lu_state_nxt == plc_pkg::PLC_LU_FAIL);
    end
  end

  // test pattern sources; set alternates every cycle while mode 4 is selected
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      test4_phase_r <= 1'b0;
      test_second_set_r <= 1'b0;
      test_data_r <= 8'h00;
      test_data_valid_r <= 1'b0;
    end else begin
      if (test_mode_sel == plc_pkg::PLC_TEST_MODE_4) begin
        test4_phase_r <= ~test4_phase_r;
        test_second_set_r <= test4_phase_r ^ pattern_four_symbol_order;
      end else begin
        test4_phase_r <= 1'b0;
        test_second_set_r <= 1'b0;
      end
      if (test_mode_sel == plc_pkg::PLC_TEST_MODE_7) begin
        test_data_r <= test7_data;
        test_data_valid_r <= 1'b1;
      end else begin
        test_data_r <= 8'h00;
        test_data_valid_r <= 1'b0;
      end
    end
  end

endmodule // plc_regs
`default_nettype wire

//--- plc_regs_assertions.sv
// port checker for the link configuration register block
`timescale 1ns/1ps
`default_nettype none
module plc_regs_chk (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic mdc,
  input wire logic mdio_in,
  input wire logic mdio_out_r,
  input wire logic mdio_oe_r,
  input wire logic fec_decode_skip_r,
  input wire logic tx_wakeup_req,
  input wire logic tx_doze_req,
  input wire logic [2:0] tx_code_group_r,
  input wire logic tx_code_valid_r,
  input wire logic rx_code_valid,
  input wire logic [2:0] rx_code_group,
  input wire logic wakeup_received_r,
  input wire logic doze_received_r,
  input wire logic linkup_start,
  input wire logic link_ready,
  input wire logic link_status_r,
  input wire logic linkup_timeout_r,
  input wire logic [2:0] test_mode_sel,
  input wire logic test_second_set_r,
  input wire logic [7:0] test_data_r,
  input wire logic test_data_valid_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // cycles since link-up began; saturates so a stuck run stays above the bound
  logic [12:0] run_cnt_r;
  always_ff @(posedge core_clk) begin
    if (!resetn || !linkup_start) run_cnt_r <= 13'h0000;
    else if (run_cnt_r != 13'h1FFF) run_cnt_r <= run_cnt_r + 13'h0001;
  end
  sequence s_any_tx_req;
    tx_wakeup_req || tx_doze_req;
  endsequence
  sequence s_mode4_run;
    (test_mode_sel == plc_pkg::PLC_TEST_MODE_4) [*3];
  endsequence
  property p_tx_send;
    s_any_tx_req |=> tx_code_valid_r;
  endproperty
  property p_tx_idle;
    !tx_wakeup_req && !tx_doze_req |=> !tx_code_valid_r && tx_code_group_r == 3'h0;
  endproperty
  property p_t7_on;
    test_mode_sel == plc_pkg::PLC_TEST_MODE_7 |=> test_data_valid_r;
  endproperty
  property p_t7_off;
    test_mode_sel != plc_pkg::PLC_TEST_MODE_7 |=> !test_data_valid_r && test_data_r == 8'h00;
  endproperty
  property p_t4_alt;
    s_mode4_run |-> test_second_set_r != $past(test_second_set_r);
  endproperty
  property p_t4_off;
    test_mode_sel != plc_pkg::PLC_TEST_MODE_4 |=> !test_second_set_r;
  endproperty
  property p_wake_hold;
    !rx_code_valid |=> $stable(wakeup_received_r);
  endproperty
  property p_doze_hold;
    !rx_code_valid |=> $stable(doze_received_r);
  endproperty
  property p_to_clear;
    !linkup_start |=> !linkup_timeout_r;
  endproperty
  // max wait is at least one 16 us unit
  property p_to_late;
    $rose(linkup_timeout_r) |-> run_cnt_r >= 13'h0FA0;
  endproperty
  a_tx_send: assert property (p_tx_send) else $error("tx code not sent");
  a_tx_idle: assert property (p_tx_idle) else $error("tx code while idle");
  a_t7_on: assert property (p_t7_on) else $error("mode 7 data missing");
  a_t7_off: assert property (p_t7_off) else $error("mode 7 data outside mode");
  a_t4_alt: assert property (p_t4_alt) else $error("mode 4 sets not alternating");
  a_t4_off: assert property (p_t4_off) else $error("mode 4 set outside mode");
  a_wake_hold: assert property (p_wake_hold) else $error("wake moved idle");
  a_doze_hold: assert property (p_doze_hold) else $error("sleep moved idle");
  a_to_clear: assert property (p_to_clear) else $error("timeout kept in idle");
  a_to_late: assert property (p_to_late) else $error("timeout too early");
endmodule // plc_regs_chk
bind plc_regs plc_regs_chk i_chk (.*);
`default_nettype wire

//--- plc_mdio_host.sv
// station manager model on the serial management pins
`timescale 1ns/1ps
`default_nettype none
module plc_mdio_host (
  input wire logic dev_oe,
  input wire logic dev_out,
  output logic mdc,
  output logic mdio_line
);
  // six core cycles per level, above the three that the pin sync needs
  localparam time HALF = 24ns;
  logic drv_oe;
  logic drv_val;
  // line is pulled up, so released means one
  assign mdio_line = dev_oe ? dev_out : (drv_oe ? drv_val : 1'b1);
  initial begin
    mdc = 1'b0;
    drv_oe = 1'b0;
    drv_val = 1'b1;
  end
  // full preamble each frame; clock stands low between frames
  task automatic xfer(input logic [1:0] op, input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    f = {32'hFFFFFFFF, 2'b00, op, plc_pkg::PLC_PORT_ADDR, plc_pkg::PLC_DEV_ADDR, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      drv_oe = !(op[1] && i < 18);
      drv_val = f[i];
      #HALF mdc = 1'b1;
      if (i < 16) rd[i] = mdio_line;
      #HALF mdc = 1'b0;
    end
    // released a half period later so back-to-back frames never retoggle in one step
    #HALF drv_oe = 1'b0;
  endtask
endmodule // plc_mdio_host
`default_nettype wire

//--- testbench.sv
// self-checking bench for the link configuration register block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk, resetn, mdc, mdio_in, mdio_out_r, mdio_oe_r, fec_decode_skip_r;
  logic tx_wakeup_req, tx_doze_req, tx_code_valid_r, rx_code_valid;
  logic wakeup_received_r, doze_received_r, linkup_start, link_ready;
  logic link_status_r, linkup_timeout_r, test_second_set_r, test_data_valid_r;
  logic [2:0] tx_code_group_r, rx_code_group, test_mode_sel, wc, dc, ew, ed;
  logic [7:0] test_data_r;
  logic [15:0] rd, v;
  logic [15:0] exp_q[$];
  logic [15:0] obs_q[$];
  int n_mismatch = 0;
  int n_tests = 0;

  plc_regs i_dut (.*);
  plc_mdio_host i_host (.dev_oe(mdio_oe_r), .dev_out(mdio_out_r), .mdc(mdc), .mdio_line(mdio_in));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic note(input logic [15:0] e, input logic [15:0] o);
    exp_q.push_back(e);
    obs_q.push_back(o);
  endtask

  task automatic compare(input logic [15:0] e, input logic [15:0] o);
    n_tests++;
    if (o !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, o, e);
    end
  endtask

  initial begin
    forever begin
      wait (obs_q.size() > 0);
      compare(exp_q.pop_front(), obs_q.pop_front());
    end
  end

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    i_host.xfer(plc_pkg::PLC_OP_ADDR, a, rd);
    i_host.xfer(plc_pkg::PLC_OP_WRITE, d, rd);
    repeat (4) @(negedge core_clk);
  endtask

  task automatic rc(input logic [15:0] a, input logic [15:0] e);
    i_host.xfer(plc_pkg::PLC_OP_ADDR, a, rd);
    i_host.xfer(plc_pkg::PLC_OP_READ, 16'h0000, rd);
    note(e, rd);
  endtask

  // group released to its inverse so no stale value lingers
  task automatic rx(input logic [2:0] g, input int n);
    rx_code_group = g;
    rx_code_valid = 1'b1;
    repeat (n) @(negedge core_clk);
    rx_code_valid = 1'b0;
    rx_code_group = ~g;
    repeat (2) @(negedge core_clk);
  endtask

  task automatic final_report;
    wait (obs_q.size() == 0);
    #1;
    $display("TB: mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #360000;
    n_mismatch++;
    final_report;
  end

  initial begin
    resetn = 1'b0;
    tx_wakeup_req = 1'b0;
    tx_doze_req = 1'b0;
    rx_code_valid = 1'b0;
    rx_code_group = 3'h0;
    linkup_start = 1'b0;
    link_ready = 1'b0;
    test_mode_sel = 3'h0;
    v = 16'($urandom(32'h37D3));
    repeat (10) @(negedge core_clk);
    resetn = 1'b1;
    note(16'h0000, {15'h0000, fec_decode_skip_r});
    for (int i = 0; i < plc_pkg::PLC_NUM_REGS; i++) begin
      rc(plc_pkg::PLC_REG_OFFSET[i], plc_pkg::PLC_REG_RESET[i]);
    end
    for (int i = 0; i < plc_pkg::PLC_NUM_REGS; i++) begin
      v = 16'($urandom);
      wr(plc_pkg::PLC_REG_OFFSET[i], v);
      rc(plc_pkg::PLC_REG_OFFSET[i], v & plc_pkg::PLC_REG_WMASK[i]);
    end
    wr(16'h0511, 16'hFFFF);
    rc(16'h0511, 16'h0000);
    wr(plc_pkg::PLC_OFF_FEC_DECODER_CONTROL, 16'h8000);
    note(16'h0001, {15'h0000, fec_decode_skip_r});
    wr(plc_pkg::PLC_OFF_FEC_DECODER_CONTROL, 16'h7FFF);
    note(16'h0000, {15'h0000, fec_decode_skip_r});
    wc = 3'($urandom);
    dc = ~wc;
    ew = 3'($urandom);
    ed = ew ^ 3'h1;
    wr(plc_pkg::PLC_OFF_LOW_POWER_CODE_SELECT, {4'h0, wc, dc, ew, ed});
    tx_doze_req = 1'b1;
    @(negedge core_clk);
    note({12'h000, 1'b1, dc}, {12'h000, tx_code_valid_r, tx_code_group_r});
    tx_wakeup_req = 1'b1;
    @(negedge core_clk);
    note({12'h000, 1'b1, wc}, {12'h000, tx_code_valid_r, tx_code_group_r});
    tx_wakeup_req = 1'b0;
    tx_doze_req = 1'b0;
    // thresholds of three wake and two sleep groups
    wr(plc_pkg::PLC_OFF_LOW_POWER_CODE_THRESHOLDS, 16'h0302);
    rx(ew, 2);
    rx(ed, 1);
    rx(ew, 2);
    note(16'h0000, {14'h0000, wakeup_received_r, doze_received_r});
    rx(ew, 1);
    note(16'h0002, {14'h0000, wakeup_received_r, doze_received_r});
    rx(ed, 2);
    note(16'h0001, {14'h0000, wakeup_received_r, doze_received_r});
    // read with increment walks from the code register to the threshold register
    i_host.xfer(plc_pkg::PLC_OP_ADDR, plc_pkg::PLC_OFF_LOW_POWER_CODE_SELECT, rd);
    i_host.xfer(plc_pkg::PLC_OP_READ_INC, 16'h0000, rd);
    note({4'h0, wc, dc, ew, ed}, rd);
    i_host.xfer(plc_pkg::PLC_OP_READ, 16'h0000, rd);
    note(16'h0302, rd);
    // one unit of min wait, two of max wait
    wr(plc_pkg::PLC_OFF_LINKUP_MAX_WAIT, 16'h0002);
    wr(plc_pkg::PLC_OFF_LINK_FORCE_AND_MIN_WAIT, 16'h0001);
    linkup_start = 1'b1;
    repeat (7900) @(negedge core_clk);
    note(16'h0000, {15'h0000, linkup_timeout_r});
    repeat (200) @(negedge core_clk);
    note(16'h0001, {15'h0000, linkup_timeout_r});
    linkup_start = 1'b0;
    repeat (2) @(negedge core_clk);
    note(16'h0000, {15'h0000, linkup_timeout_r});
    link_ready = 1'b1;
    linkup_start = 1'b1;
    repeat (3900) @(negedge core_clk);
    note(16'h0000, {15'h0000, link_status_r});
    repeat (200) @(negedge core_clk);
    note(16'h0001, {15'h0000, link_status_r});
    wr(plc_pkg::PLC_OFF_LINK_FORCE_AND_MIN_WAIT, 16'h0401);
    note(16'h0000, {15'h0000, link_status_r});
    wr(plc_pkg::PLC_OFF_LINK_FORCE_AND_MIN_WAIT, 16'h0801);
    note(16'h0001, {15'h0000, link_status_r});
    link_ready = 1'b0;
    repeat (3) @(negedge core_clk);
    note(16'h0000, {15'h0000, link_status_r});
    wr(plc_pkg::PLC_OFF_LINK_FORCE_AND_MIN_WAIT, 16'h0C01);
    note(16'h0001, {15'h0000, link_status_r});
    linkup_start = 1'b0;
    for (int o = 0; o < 2; o++) begin
      wr(plc_pkg::PLC_OFF_TRANSMIT_TEST_PATTERN_CONTROL, {7'h00, 1'(o), v[7:0]});
      test_mode_sel = plc_pkg::PLC_TEST_MODE_4;
      @(negedge core_clk);
      note({15'h0000, 1'(o)}, {15'h0000, test_second_set_r});
      @(negedge core_clk);
      note({15'h0000, ~1'(o)}, {15'h0000, test_second_set_r});
      @(negedge core_clk);
      note({15'h0000, 1'(o)}, {15'h0000, test_second_set_r});
      test_mode_sel = plc_pkg::PLC_TEST_MODE_7;
      repeat (2) @(negedge core_clk);
      note({7'h00, 1'b1, v[7:0]}, {7'h00, test_data_valid_r, test_data_r});
      test_mode_sel = 3'h0;
      v = 16'($urandom);
    end
    final_report;
  end
endmodule // testbench
`default_nettype wire
